// ---- rtl/wdc_top.sv ----
// Purpose: window watchdog configuration, timing and escalation
// Assumes: register port, service, sleep and reset-release strobes come
//          from logic on CLK_SYS, so none of them is synchronised
// Notes:   write-lock bits come from the protection registers outside
`timescale 1ns/1ns
`default_nettype none
`include "wdc_map.svh"

// Operation
// - action select zero keeps the watchdog off with no expiry effects.
// - action 01b escalates interrupt, then reset, then forced power-down.
// - action 10b escalates reset first, then forced power-down, no interrupt.
// - action 11b forces power-down on every expiry.
// - run-in-sleep clear stops the watchdog in sleep; set keeps it running.
// - first closed window waits delay code plus one full watchdog periods.
// - delay restarts on reset release, config write, non-volatile load, or sleep exit if stopped.
// - forced power-down copies shutdown mode into the forced shutdown field.
// - closed window code resolution is 1, 2 or 4 ms by band.
// - closed window decodes 1 ms base, 34 ms at 20h, 100 ms at 40h.
// - registers load from non-volatile memory and ignore writes when locked.
// - open window code decodes exactly like the closed window code.
module wdc_top
    import wdc_pkg::*;
#(
    parameter int MS_CYCLES = `WDC_MS_CYCLES
)(
    // clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    // non-volatile load
    input  wire logic       NVM_LOAD,
    input  wire logic [7:0] NVM_CFG,
    input  wire logic [7:0] NVM_CLOSE,
    input  wire logic [7:0] NVM_OPEN,
    // register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WE,
    input  wire logic       REG_RE,
    output logic      [7:0] REG_RDATA,
    // protection bits of the watchdog group
    input  wire logic       LOCK_A_WDT,
    input  wire logic       LOCK_B_WDT,
    // device events
    input  wire logic       WD_SERVICE,
    input  wire logic       SLEEP_ACTIVE,
    input  wire logic       RST_OUT_RELEASE,
    // escalation outputs
    output logic            WD_IRQ,
    output logic            WD_RESET_REQ,
    output logic            WD_PWRDN_REQ,
    output logic      [1:0] FORCED_SHDN_CODE,
    output logic            FORCED_SHDN_WE,
    // status
    output logic      [1:0] WD_PHASE,
    output logic      [1:0] WD_STAGE
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam logic [15:0] TICK_LAST = 16'(MS_CYCLES - 1);

    // ------------------------------------------------------------------
    // state and decoders
    // ------------------------------------------------------------------
    wdc_state_s s_r;
    wdc_state_s s_nxt;
    wdc_ms_t    close_ms;
    wdc_ms_t    open_ms;
    wdc_cnt_t   period_ms;
    wdc_cnt_t   ms_inc;
    logic       locked;
    logic       cfg_wr;
    logic       tick;
    logic       paused;
    logic       restart;
    logic       expire;
    logic       good;
    wdc_act_e   act;

    wdc_window_decode u_close_dec (
        .code   (s_r.close_code),
        .len_ms (close_ms)
    );

    wdc_window_decode u_open_dec (
        .code   (s_r.open_code),
        .len_ms (open_ms)
    );

    // period is closed plus open window
    assign period_ms = {1'b0, close_ms} + {1'b0, open_ms};
    assign ms_inc    = s_r.ms_cnt + 11'h001;
    assign locked    = LOCK_A_WDT && LOCK_B_WDT;
    assign tick      = (s_r.tick_cnt == TICK_LAST);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.irq_p    = 1'b0;
        s_nxt.rst_p    = 1'b0;
        s_nxt.pwr_p    = 1'b0;
        s_nxt.fshdn_we = 1'b0;
        expire         = 1'b0;
        good           = 1'b0;

        // register writes; lock only blocks the host, not the load
        cfg_wr = REG_WE && !locked && (REG_ADDR == `WDC_ADDR_CFG);
        if (NVM_LOAD) begin
            s_nxt.cfg        = NVM_CFG;
            s_nxt.close_code = NVM_CLOSE;
            s_nxt.open_code  = NVM_OPEN;
        end else if (REG_WE && !locked) begin
            case (REG_ADDR)
                `WDC_ADDR_CFG:   s_nxt.cfg        = REG_WDATA;
                `WDC_ADDR_CLOSE: s_nxt.close_code = REG_WDATA;
                `WDC_ADDR_OPEN:  s_nxt.open_code  = REG_WDATA;
                default: ;
            endcase
        end

        if (REG_RE) begin
            case (REG_ADDR)
                `WDC_ADDR_CFG:   s_nxt.rd_data = s_r.cfg;
                `WDC_ADDR_CLOSE: s_nxt.rd_data = s_r.close_code;
                `WDC_ADDR_OPEN:  s_nxt.rd_data = s_r.open_code;
                default:         s_nxt.rd_data = 8'h00;
            endcase
        end

        // millisecond timebase, cleared whenever the delay restarts
        s_nxt.tick_cnt = tick ? 16'h0000 : 16'(s_r.tick_cnt + 16'h0001);

        // window sequencing
        case (s_r.phase)
            WDC_PH_OFF: begin
            end
            WDC_PH_DELAY: begin
                // service during the delay is neither good nor bad
                if (tick) begin
                    if (ms_inc >= period_ms) begin
                        s_nxt.ms_cnt = '0;
                        if (s_r.periods_left == 3'h0) begin
                            s_nxt.phase = WDC_PH_CLOSED;
                        end else begin
                            s_nxt.periods_left = 3'(s_r.periods_left - 3'h1);
                        end
                    end else begin
                        s_nxt.ms_cnt = ms_inc;
                    end
                end
            end
            WDC_PH_CLOSED: begin
                if (WD_SERVICE) begin
                    expire       = 1'b1;
                    s_nxt.ms_cnt = '0;
                end else if (tick) begin
                    if (ms_inc >= {1'b0, close_ms}) begin
                        s_nxt.phase  = WDC_PH_OPEN;
                        s_nxt.ms_cnt = '0;
                    end else begin
                        s_nxt.ms_cnt = ms_inc;
                    end
                end
            end
            WDC_PH_OPEN: begin
                if (WD_SERVICE) begin
                    good         = 1'b1;
                    s_nxt.phase  = WDC_PH_CLOSED;
                    s_nxt.ms_cnt = '0;
                end else if (tick) begin
                    if (ms_inc >= {1'b0, open_ms}) begin
                        expire       = 1'b1;
                        s_nxt.phase  = WDC_PH_CLOSED;
                        s_nxt.ms_cnt = '0;
                    end else begin
                        s_nxt.ms_cnt = ms_inc;
                    end
                end
            end
            default: begin
                s_nxt.phase = WDC_PH_OFF;
            end
        endcase

        // escalation on expiry, using the settings in force now
        act = wdc_act_e'(s_r.cfg[`WDC_ACT_HI:`WDC_ACT_LO]);
        if (expire) begin
            case (act)
                WDC_ACT_IRQ_FIRST: begin
                    s_nxt.irq_p = (s_r.stage == 2'h0);
                    s_nxt.rst_p = (s_r.stage == 2'h1);
                    s_nxt.pwr_p = (s_r.stage >= 2'h2);
                end
                WDC_ACT_RST_FIRST: begin
                    s_nxt.rst_p = (s_r.stage == 2'h0);
                    s_nxt.pwr_p = (s_r.stage != 2'h0);
                end
                WDC_ACT_PWR_ONLY: begin
                    s_nxt.pwr_p = 1'b1;
                end
                default: ;
            endcase
            if (s_r.stage != 2'h2) begin
                s_nxt.stage = 2'(s_r.stage + 2'h1);
            end
        end
        if (good) begin
            s_nxt.stage = 2'h0;
        end
        if (s_nxt.pwr_p) begin
            s_nxt.fshdn_code = s_r.cfg[`WDC_PDM_HI:`WDC_PDM_LO];
            s_nxt.fshdn_we   = 1'b1;
        end

        // stop, disable and restart take the freshly written settings
        act           = wdc_act_e'(s_nxt.cfg[`WDC_ACT_HI:`WDC_ACT_LO]);
        paused        = SLEEP_ACTIVE && !s_nxt.cfg[`WDC_SLP_BIT];
        s_nxt.sleep_d = SLEEP_ACTIVE;
        restart       = cfg_wr || NVM_LOAD || RST_OUT_RELEASE ||
                        (s_r.sleep_d && !SLEEP_ACTIVE &&
                         !s_nxt.cfg[`WDC_SLP_BIT]);
        if (act == WDC_ACT_OFF) begin
            s_nxt.phase = WDC_PH_OFF;
            s_nxt.stage = 2'h0;
            s_nxt.irq_p = 1'b0;
            s_nxt.rst_p = 1'b0;
            s_nxt.pwr_p = 1'b0;
            s_nxt.fshdn_we   = 1'b0;
            s_nxt.fshdn_code = s_r.fshdn_code;
        end else if (paused) begin
            // counting frozen; sleep exit reopens with a full delay
            s_nxt.phase = WDC_PH_OFF;
        end else if (restart || (s_r.phase == WDC_PH_OFF)) begin
            s_nxt.phase        = WDC_PH_DELAY;
            s_nxt.periods_left = s_nxt.cfg[`WDC_DLY_HI:`WDC_DLY_LO];
            s_nxt.ms_cnt       = '0;
            s_nxt.tick_cnt     = 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s_r              <= '0;
            s_r.cfg          <= `WDC_CFG_RST;
            s_r.close_code   <= `WDC_CLOSE_RST;
            s_r.open_code    <= `WDC_OPEN_RST;
            s_r.phase        <= WDC_PH_OFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign REG_RDATA        = s_r.rd_data;
    assign WD_IRQ           = s_r.irq_p;
    assign WD_RESET_REQ     = s_r.rst_p;
    assign WD_PWRDN_REQ     = s_r.pwr_p;
    assign FORCED_SHDN_CODE = s_r.fshdn_code;
    assign FORCED_SHDN_WE   = s_r.fshdn_we;
    assign WD_PHASE         = s_r.phase;
    assign WD_STAGE         = s_r.stage;

endmodule
`default_nettype wire

// ---- rtl/wdc_map.svh ----
// Purpose: offsets, field positions, reset values and timing of the
//          window watchdog configuration block
// Assumes: byte-wide registers behind the device's own register port
// Notes:   definitions only
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define WDC_ADDR_CFG    8'h80
`define WDC_ADDR_CLOSE  8'h81
`define WDC_ADDR_OPEN   8'h82

// ----------------------------------------------------------------------
// watchdog_config fields
// ----------------------------------------------------------------------
`define WDC_ACT_HI      7
`define WDC_ACT_LO      6
`define WDC_SLP_BIT     5
`define WDC_DLY_HI      4
`define WDC_DLY_LO      2
`define WDC_PDM_HI      1
`define WDC_PDM_LO      0

// ----------------------------------------------------------------------
// reset values until the non-volatile load arrives
// ----------------------------------------------------------------------
`define WDC_CFG_RST     8'h00
`define WDC_CLOSE_RST   8'h00
`define WDC_OPEN_RST    8'h00

// ----------------------------------------------------------------------
// window code bands
// ----------------------------------------------------------------------
`define WDC_BAND2_CODE  8'h20
`define WDC_BAND3_CODE  8'h40
`define WDC_BAND1_BASE  10'h001
`define WDC_BAND2_BASE  10'h022
`define WDC_BAND3_BASE  10'h064

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define WDC_MS_NS       1000000
`define WDC_CLK_NS      100
`define WDC_MS_CYCLES   (`WDC_MS_NS / `WDC_CLK_NS)

`endif

// ---- rtl/wdc_pkg.sv ----
// Purpose: types of the window watchdog configuration block
// Assumes: widths fixed here are wide enough for the documented ranges
// Notes:   constants live in wdc_map.svh
package wdc_pkg;

    typedef enum logic [1:0] {
        WDC_ACT_OFF,
        WDC_ACT_IRQ_FIRST,
        WDC_ACT_RST_FIRST,
        WDC_ACT_PWR_ONLY
    } wdc_act_e;

    typedef enum logic [1:0] {
        WDC_PH_OFF,
        WDC_PH_DELAY,
        WDC_PH_CLOSED,
        WDC_PH_OPEN
    } wdc_phase_e;

    typedef logic [9:0]  wdc_ms_t;
    typedef logic [10:0] wdc_cnt_t;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  close_code;
        logic [7:0]  open_code;
        logic [7:0]  rd_data;
        wdc_phase_e  phase;
        logic [15:0] tick_cnt;
        wdc_cnt_t    ms_cnt;
        logic [2:0]  periods_left;
        logic [1:0]  stage;
        logic        sleep_d;
        logic        irq_p;
        logic        rst_p;
        logic        pwr_p;
        logic [1:0]  fshdn_code;
        logic        fshdn_we;
    } wdc_state_s;

endpackage

// ---- rtl/wdc_window_decode.sv ----
// Purpose: window length code to milliseconds
// Assumes: three resolution bands of 1, 2 and 4 ms
// Notes:   purely combinational, used for both windows
`timescale 1ns/1ns
`default_nettype none
`include "wdc_map.svh"

module wdc_window_decode
    import wdc_pkg::*;
(
    // code in
    input  wire logic [7:0] code,
    // length out
    output wdc_ms_t         len_ms
);

    logic [7:0] off2;
    logic [7:0] off3;

    assign off2 = code - `WDC_BAND2_CODE;
    assign off3 = code - `WDC_BAND3_CODE;

    always_comb begin
        if (code < `WDC_BAND2_CODE) begin
            len_ms = `WDC_BAND1_BASE + {2'h0, code};
        end else if (code < `WDC_BAND3_CODE) begin
            len_ms = `WDC_BAND2_BASE + {1'h0, off2, 1'h0};
        end else begin
            len_ms = `WDC_BAND3_BASE + {off3, 2'h0};
        end
    end

endmodule
`default_nettype wire

// ---- sim/wdc_checker.sv ----
// Purpose: port checks of the watchdog configuration block
// Assumes: pulses and status registered on CLK_SYS
// Notes:   bound into wdc_top
`timescale 1ns/1ns
`default_nettype none
module wdc_checker #(
    parameter int MS_CYCLES = 10000
)(
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       RST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_RE,
    input wire logic [7:0] REG_RDATA,
    // events
    input wire logic       WD_SERVICE,
    input wire logic       RST_OUT_RELEASE,
    // escalation and status
    input wire logic       WD_IRQ,
    input wire logic       WD_RESET_REQ,
    input wire logic       WD_PWRDN_REQ,
    input wire logic [1:0] FORCED_SHDN_CODE,
    input wire logic       FORCED_SHDN_WE,
    input wire logic [1:0] WD_PHASE,
    input wire logic [1:0] WD_STAGE
);
    logic any_p;
    logic mapped;
    assign any_p  = WD_IRQ | WD_RESET_REQ | WD_PWRDN_REQ;
    assign mapped = REG_ADDR inside {8'h80, 8'h81, 8'h82};
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_off; WD_PHASE == 2'h0 |-> !any_p; endproperty
    a_off: assert property (p_off)
        else $error("pulse while off");
    property p_irq; WD_IRQ |-> WD_STAGE == 2'h1 && !WD_PWRDN_REQ; endproperty
    a_irq: assert property (p_irq)
        else $error("irq not first");
    property p_rst; WD_RESET_REQ |-> WD_STAGE != 2'h0 && !WD_IRQ; endproperty
    a_rst: assert property (p_rst)
        else $error("reset step wrong");
    property p_we; FORCED_SHDN_WE == WD_PWRDN_REQ; endproperty
    a_we: assert property (p_we)
        else $error("shutdown copy apart from power-down");
    property p_code;
        !FORCED_SHDN_WE |-> $stable(FORCED_SHDN_CODE);
    endproperty
    a_code: assert property (p_code)
        else $error("shutdown code moved");
    property p_bad; WD_PHASE == 2'h2 && WD_SERVICE |=> any_p; endproperty
    a_bad: assert property (p_bad)
        else $error("closed service not expired");
    property p_good;
        WD_PHASE == 2'h3 && WD_SERVICE |=> WD_STAGE == 2'h0;
    endproperty
    a_good: assert property (p_good)
        else $error("stage kept after service");
    property p_rel;
        RST_OUT_RELEASE && WD_PHASE != 2'h0 |=> WD_PHASE == 2'h1;
    endproperty
    a_rel: assert property (p_rel)
        else $error("release did not restart delay");
    property p_unmap; REG_RE && !mapped |=> REG_RDATA == 8'h00; endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
endmodule
bind wdc_top wdc_checker #(.MS_CYCLES(MS_CYCLES)) u_wdc_checker (.*);
`default_nettype wire

// ---- sim/wdc_host.sv ----
// Purpose: host that keys the watchdog and sets the lock bits
// Assumes: mode 0 never keys, modes 1..3 key once in that phase
// Notes:   lock bits stick until reset, standing in for a power cycle
`timescale 1ns/1ns
`default_nettype none
module wdc_host (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // bench control
    input  wire logic [1:0] mode,
    input  wire logic       lock_req,
    // device side
    input  wire logic [1:0] phase,
    output logic            service,
    output logic            lock_a,
    output logic            lock_b
);
    logic hit;
    logic done_r;
    assign hit = mode != 2'h0 && phase == mode;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            service <= 1'b0;
            done_r  <= 1'b0;
            lock_a  <= 1'b0;
            lock_b  <= 1'b0;
        end else begin
            // one key per window, a second key would itself expire
            service <= hit && !done_r;
            done_r  <= hit;
            lock_a  <= lock_a | lock_req;
            lock_b  <= lock_b | lock_req;
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: self-checking bench of the watchdog configuration block
// Assumes: 1 ms shortened to MS clocks, windows of 2 ms after load
// Notes:   pulses logged as {irq, reset, power-down}
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int MS = 4;
    logic       clk = 1'b0, rst = 1'b1, nvm_load = 1'b0, we = 1'b0;
    logic       re = 1'b0, sleep = 1'b0, rel = 1'b0, lock_req = 1'b0;
    logic [1:0] mode = 2'h0, code, phase, stage;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic       irq, rreq, preq, svc, lk_a, lk_b;
    logic [2:0] pq[$];
    logic [7:0] codes[6] = '{8'h00, 8'h1F, 8'h20, 8'h3F, 8'h40, 8'hFF};
    int         fails = 0, n_tests = 0, cyc = 0;
    wdc_top #(.MS_CYCLES(MS)) u_wdc_top (
        .CLK_SYS(clk), .RST(rst), .NVM_LOAD(nvm_load),
        .NVM_CFG(8'h03), .NVM_CLOSE(8'h01), .NVM_OPEN(8'h01),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re),
        .REG_RDATA(rdata), .LOCK_A_WDT(lk_a), .LOCK_B_WDT(lk_b),
        .WD_SERVICE(svc), .SLEEP_ACTIVE(sleep), .RST_OUT_RELEASE(rel),
        .WD_IRQ(irq), .WD_RESET_REQ(rreq), .WD_PWRDN_REQ(preq),
        .FORCED_SHDN_CODE(code), .FORCED_SHDN_WE(),
        .WD_PHASE(phase), .WD_STAGE(stage));
    wdc_host u_wdc_host (.clk(clk), .rst(rst), .mode(mode),
        .lock_req(lock_req), .phase(phase), .service(svc),
        .lock_a(lk_a), .lock_b(lk_b));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (irq | rreq | preq)
            pq.push_back({irq, rreq, preq});
        if (cyc == 60000) begin
            fails++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        check("rdata", 16'(rdata), 16'(e));
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic span(input logic [1:0] ph, output int n);
        n = 0;
        for (int i = 0; i < 9000 && phase == ph; i++) @(negedge clk);
        for (int i = 0; i < 9000 && phase != ph; i++) @(negedge clk);
        while (phase == ph && n < 9000) begin
            @(negedge clk);
            n++;
        end
    endtask
    function automatic int win(input logic [7:0] c);
        if (c < 8'h20)
            return 1 + int'(c);
        if (c < 8'h40)
            return 34 + 2 * (int'(c) - 32);
        return 100 + 4 * (int'(c) - 64);
    endfunction
    // first span may start mid-window or before the new code lands
    task automatic win_test(input logic [7:0] a, input logic [1:0] ph);
        int n;
        int e;
        foreach (codes[i]) begin
            wr(a, codes[i]);
            e = win(codes[i]) * MS;
            span(ph, n);
            span(ph, n);
            check("window", 16'(n > e - MS && n <= e), 16'h1);
        end
    endtask
    task automatic esc(input logic [7:0] c, input logic [8:0] e);
        wr(8'h80, 8'h00);
        check("stage", 16'(stage), 16'h0);
        pq.delete();
        wr(8'h80, c);
        for (int i = 0; i < 300 && pq.size() < 3; i++) @(posedge clk);
        #1;
        check("steps", 16'({pq[0], pq[1], pq[2]}), 16'(e));
        check("shdn", 16'(code), 16'(c[1:0]));
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        int n;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        nvm_load <= 1'b1;
        @(posedge clk);
        nvm_load <= 1'b0;
        rd(8'h80, 8'h03);
        rd(8'h81, 8'h01);
        rd(8'h82, 8'h01);
        rd(8'h90, 8'h00);
        step(60);
        check("quiet", 16'(pq.size()), 16'h0);
        $display("end load");
        mode <= 2'h1;
        wr(8'h80, 8'h46);
        step(29);
        check("delay", 16'(phase), 16'h1);
        step(6);
        check("closed", 16'(phase), 16'h2);
        check("delay key", 16'(pq.size()), 16'h0);
        $display("end delay");
        mode <= 2'h3;
        wr(8'h80, 8'h00);
        wr(8'h80, 8'h42);
        pq.delete();
        step(150);
        check("good key", 16'(pq.size()), 16'h0);
        span(2'h3, n);
        mode <= 2'h2;
        step(30);
        check("bad key", 16'(pq[0]), 16'h4);
        $display("end service");
        mode <= 2'h0;
        esc(8'h42, 9'b100_010_001);
        esc(8'h81, 9'b010_001_001);
        esc(8'hC3, 9'b001_001_001);
        $display("end escalation");
        mode <= 2'h3;
        wr(8'h80, 8'h42);
        step(40);
        sleep <= 1'b1;
        step(4);
        check("sleep stop", 16'(phase), 16'h0);
        sleep <= 1'b0;
        step(3);
        check("wake", 16'(phase), 16'h1);
        wr(8'h80, 8'h62);
        step(40);
        sleep <= 1'b1;
        step(40);
        check("sleep run", 16'(phase != 2'h0), 16'h1);
        sleep <= 1'b0;
        @(posedge clk);
        rel <= 1'b1;
        @(posedge clk);
        rel <= 1'b0;
        #1;
        check("release", 16'(phase), 16'h1);
        $display("end sleep");
        win_test(8'h81, 2'h2);
        wr(8'h81, 8'h01);
        mode <= 2'h0;
        win_test(8'h82, 2'h3);
        $display("end windows");
        wr(8'h80, 8'hC3);
        lock_req <= 1'b1;
        step(2);
        wr(8'h80, 8'h00);
        wr(8'h81, 8'h7E);
        rd(8'h80, 8'hC3);
        rd(8'h81, 8'h01);
        $display("end lock");
        close_out();
    end
endmodule
`default_nettype wire
